/* File: inc/iwd_cfg.svh */
// offsets, field positions, reset values and timing counts of the independent watchdog
`ifndef IWD_CFG_SVH
`define IWD_CFG_SVH

`define IWD_OFF_KEY        4'h0
`define IWD_OFF_PRESC      4'h4
`define IWD_OFF_RESTART    4'h8
`define IWD_OFF_STATUS     4'hc
`define IWD_OFF_INT_STAT   4'h0
`define IWD_OFF_INT_MASK   4'h4

`define IWD_KEY_START      16'hcccc
`define IWD_KEY_REFRESH    16'haaaa
`define IWD_KEY_UNLOCK     16'h5555

`define IWD_PRESC_RESET    3'h0
`define IWD_RESTART_RESET  12'hfff
`define IWD_STAT_PVU_BIT   0
`define IWD_STAT_RESTART_UPDATE_PENDING_BIT  1

`define IWD_SYNC_CYCLES    4'h6
`define IWD_RESET_PULSE    8'h10

`endif

/* File: inc/iwd_pkg.sv */
// types shared by the independent watchdog register block
package iwd_pkg;

    // bus request bundle
    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } iwd_bus_s;

    // counter engine states, one-hot
    typedef enum logic [2:0] {
        IWD_IDLE  = 3'b001,
        IWD_RUN   = 3'b010,
        IWD_FIRE  = 3'b100
    } iwd_state_e;

    // complete state of the block
    typedef struct packed {
        iwd_state_e  state;
        logic        unlocked;
        logic [2:0]  presc_req;
        logic [2:0]  presc_dom;
        logic [11:0] restart_req;
        logic [11:0] restart_dom;
        logic [3:0]  pvu_cnt;
        logic [3:0]  restart_update_pending_cnt;
        logic [11:0] count;
        logic [7:0]  div_cnt;
        logic [1:0]  osc_sync;
        logic        osc_prev;
        logic [7:0]  rst_cnt;
        logic        sys_reset;
        logic [1:0]  int_stat;
        logic [1:0]  int_mask;
        logic        irq;
        logic        running;
        logic [31:0] rdata;
    } iwd_state_s;

endpackage

/* File: hdl/iwd_top.sv */
// independent watchdog: key, prescaler, restart value, status and 12-bit down counter
// Register map, byte offsets on addr_in[3:0] with addr_in[4] choosing the page
//   page 0, 0x00  command key, write only, reads as zero
//   page 0, 0x04  prescaler select, bits 2:0, write protected
//   page 0, 0x08  counter restart value, bits 11:0, write protected
//   page 0, 0x0c  update status, bit 0 prescaler pending, bit 1 restart pending
//   page 1, 0x00  interrupt status, bit 0 refresh, bit 1 expiry, cleared by read
//   page 1, 0x04  interrupt mask, same layout
//
// Command keys on bits 15:0 of the key register
//   unlock   opens the prescaler and restart registers
//   start    starts the down counter, relocks
//   refresh  reloads the counter from the restart copy, relocks
//   other    relocks, nothing else
//
// Update carry-across
//   an accepted prescaler or restart write is held in a request copy and
//   the pending flag stays up for SYNC_CYCLES clocks; when it drops, the
//   value moves into the copy that the counter and the read path use.
//   while a flag is up the register shows its old value and refuses writes.
//
// Counter engine
//   idle until the start key or the hardware start option; then one
//   decrement per divided oscillator tick; a tick at zero raises the
//   system reset for RESET_PULSE plus one clocks and restarts from all ones.
//   debug_halt_in holds the divider so the count freezes in debug.
//
// Interrupts
//   refresh and expiry each set a sticky status bit; reading the status
//   clears it, but an event in the same cycle wins; irq_out is high while
//   any unmasked status bit is set.
//
// Hazards
//   the oscillator is sampled as a level through two flops, so it must run
//   well below half the system clock or edges are lost.
//   the start key only relocks while the hardware start option is set.
//   reads and writes never stall; read data stand for one cycle only.
//   a refresh while the counter is idle or firing only relocks, unless the engine enters run in that same cycle.
//   after an expiry the counter runs again from all ones; the system reset
//   it raises is expected to clear the block from outside.
//   protected or refused writes are dropped silently, with no error flag.
`timescale 1ns/1ps
`include "iwd_cfg.svh"

module iwd_top
    import iwd_pkg::*;
#(
    parameter logic [3:0] SYNC_CYCLES = `IWD_SYNC_CYCLES,   // cycles to carry an update across
    parameter logic [7:0] RESET_PULSE = `IWD_RESET_PULSE    // length of the system reset pulse
) (
    input  wire logic        sys_clk_in,        // system clock, 250 MHz
    input  wire logic        rstn_in,           // synchronous reset, active low
    input  wire logic        osc_clk_in,        // low-speed oscillator, sampled as a level
    input  wire logic        hw_start_in,       // hardware-started watchdog option
    input  wire logic        debug_halt_in,     // freeze counter while core halted in debug
    input  wire logic [4:0]  addr_in,           // byte address
    input  wire logic [31:0] wdata_in,          // write data
    input  wire logic        wr_in,             // write strobe
    input  wire logic        rd_in,             // read strobe
    output logic      [31:0] rdata_out,         // read data, one cycle after rd_in
    output logic             sys_reset_out,     // system reset request
    output logic             running_out,       // counter engine out of idle, high in run and fire
    output logic      [11:0] count_out,         // present counter value
    output logic             irq_out            // level interrupt
);

    // ------------------------------------------------------------
    // state and bus bundle
    // ------------------------------------------------------------
    // st_ff holds every register of the block; nxt_st is built by the one
    // combinational process and loaded on every clock edge while rstn_in is high
    iwd_state_s st_ff;       // registered state
    iwd_state_s nxt_st;      // next state
    iwd_bus_s   bus;         // incoming request

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // prescaler code to divide ratio minus one
    // codes 0 to 5 give 4 shifted by the code, the rest saturate at 256
    function automatic logic [7:0] div_limit(input logic [2:0] code);
        logic [7:0] r;
        r = 8'hff;                               // /256 for codes 110 and 111
        if (code <= 3'h5) begin
            r = 8'((9'h004 << code) - 9'h001);
        end
        return r;
    endfunction

    // register-page decode
    // page bit is addr_in[4], offset the low four bits
    function automatic logic hit(input iwd_bus_s b, input logic page, input logic [3:0] off);
        return (b.addr[4] == page) && (b.addr[3:0] == off);
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic       tick;        // divided oscillator tick
        logic [1:0] ev;          // events raised this cycle
        logic [7:0] lim;         // current divide limit
        nxt_st = st_ff;
        tick   = 1'b0;
        ev     = 2'b00;
        lim    = div_limit(st_ff.presc_dom);

        // ------------------------------------------------------------
        // oscillator sampling
        // ------------------------------------------------------------
        // oscillator sampled through two flops, edge taken from the second
        nxt_st.osc_sync = {st_ff.osc_sync[0], osc_clk_in};
        nxt_st.osc_prev = st_ff.osc_sync[1];

        // ------------------------------------------------------------
        // update carry-across
        // ------------------------------------------------------------
        // update carry-across counters; flag is high while non-zero
        if (st_ff.pvu_cnt != 4'h0) begin
            nxt_st.pvu_cnt = st_ff.pvu_cnt - 4'h1;
            if (st_ff.pvu_cnt == 4'h1) begin
                nxt_st.presc_dom = st_ff.presc_req;
            end
        end
        if (st_ff.restart_update_pending_cnt != 4'h0) begin
            nxt_st.restart_update_pending_cnt = st_ff.restart_update_pending_cnt - 4'h1;
            if (st_ff.restart_update_pending_cnt == 4'h1) begin
                nxt_st.restart_dom = st_ff.restart_req;
            end
        end

        // hardware start option runs the counter at once
        if (hw_start_in && st_ff.state == IWD_IDLE) begin
            nxt_st.state = IWD_RUN;
            nxt_st.count = `IWD_RESTART_RESET;
        end

        // ------------------------------------------------------------
        // counter engine
        // ------------------------------------------------------------
        // states are one-hot: idle, run, fire
        unique case (st_ff.state)
            IWD_IDLE: begin
                nxt_st.div_cnt = 8'h00;
            end
            IWD_RUN: begin
                if (st_ff.osc_sync[1] && !st_ff.osc_prev && !debug_halt_in) begin
                    if (st_ff.div_cnt >= lim) begin
                        nxt_st.div_cnt = 8'h00;
                        tick = 1'b1;
                    end else begin
                        nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
                    end
                end
                if (tick) begin
                    if (st_ff.count == 12'h000) begin
                        nxt_st.state     = IWD_FIRE;
                        nxt_st.sys_reset = 1'b1;
                        nxt_st.rst_cnt   = RESET_PULSE;
                        ev[1]            = 1'b1;
                    end else begin
                        nxt_st.count = st_ff.count - 12'h001;
                    end
                end
            end
            IWD_FIRE: begin
                // hold reset for a fixed pulse, then restart from all ones
                if (st_ff.rst_cnt == 8'h00) begin
                    nxt_st.sys_reset = 1'b0;
                    nxt_st.state     = IWD_RUN;
                    nxt_st.count     = `IWD_RESTART_RESET;
                end else begin
                    nxt_st.rst_cnt = st_ff.rst_cnt - 8'h01;
                end
            end
        endcase

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        // key writes: any key but unlock closes the protected registers
        if (bus.wr && hit(bus, 1'b0, `IWD_OFF_KEY)) begin
            unique case (bus.wdata[15:0])
                `IWD_KEY_UNLOCK: begin
                    nxt_st.unlocked = 1'b1;
                end
                `IWD_KEY_START: begin
                    nxt_st.unlocked = 1'b0;
                    if (st_ff.state == IWD_IDLE && !hw_start_in) begin
                        nxt_st.state = IWD_RUN;
                        nxt_st.count = `IWD_RESTART_RESET;
                    end
                end
                `IWD_KEY_REFRESH: begin
                    nxt_st.unlocked = 1'b0;
                    if (nxt_st.state == IWD_RUN) begin
                        nxt_st.count   = st_ff.restart_dom;
                        nxt_st.div_cnt = 8'h00;
                        ev[0]          = 1'b1;
                    end
                end
                default: begin
                    nxt_st.unlocked = 1'b0;
                end
            endcase
        end
        // prescaler write needs unlock and no update in flight
        if (bus.wr && hit(bus, 1'b0, `IWD_OFF_PRESC)
            && st_ff.unlocked && st_ff.pvu_cnt == 4'h0) begin
            nxt_st.presc_req = bus.wdata[2:0];
            nxt_st.pvu_cnt   = SYNC_CYCLES;
        end
        // restart write needs unlock and no update in flight
        if (bus.wr && hit(bus, 1'b0, `IWD_OFF_RESTART)
            && st_ff.unlocked && st_ff.restart_update_pending_cnt == 4'h0) begin
            nxt_st.restart_req = bus.wdata[11:0];
            nxt_st.restart_update_pending_cnt    = SYNC_CYCLES;
        end
        // interrupt mask, not protected
        if (bus.wr && hit(bus, 1'b1, `IWD_OFF_INT_MASK)) begin
            nxt_st.int_mask = bus.wdata[1:0];
        end

        // ------------------------------------------------------------
        // register reads
        // ------------------------------------------------------------
        // register reads, answer in the next cycle
        nxt_st.rdata = 32'h0000_0000;
        if (bus.rd) begin
            if (hit(bus, 1'b0, `IWD_OFF_PRESC)) begin
                nxt_st.rdata[2:0] = st_ff.presc_dom;
            end else if (hit(bus, 1'b0, `IWD_OFF_RESTART)) begin
                nxt_st.rdata[11:0] = st_ff.restart_dom;
            end else if (hit(bus, 1'b0, `IWD_OFF_STATUS)) begin
                nxt_st.rdata[`IWD_STAT_PVU_BIT]  = (st_ff.pvu_cnt != 4'h0);
                nxt_st.rdata[`IWD_STAT_RESTART_UPDATE_PENDING_BIT] = (st_ff.restart_update_pending_cnt != 4'h0);
            end else if (hit(bus, 1'b1, `IWD_OFF_INT_STAT)) begin
                nxt_st.rdata[1:0] = st_ff.int_stat;
                nxt_st.int_stat   = 2'b00;              // read clears
            end else if (hit(bus, 1'b1, `IWD_OFF_INT_MASK)) begin
                nxt_st.rdata[1:0] = st_ff.int_mask;
            end
        end

        // ------------------------------------------------------------
        // interrupts and output flags
        // ------------------------------------------------------------
        // new events win over the read clear
        nxt_st.int_stat = nxt_st.int_stat | ev;
        // level interrupt, registered so irq_out comes from a flop
        nxt_st.irq      = |(nxt_st.int_stat & st_ff.int_mask);

        // running flag mirrors the engine state, kept in a flop for the output
        nxt_st.running  = (nxt_st.state != IWD_IDLE);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset loads the default values; every other field clears
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            st_ff             <= '0;
            st_ff.state       <= IWD_IDLE;
            st_ff.presc_req   <= `IWD_PRESC_RESET;
            st_ff.presc_dom   <= `IWD_PRESC_RESET;
            st_ff.restart_req <= `IWD_RESTART_RESET;
            st_ff.restart_dom <= `IWD_RESTART_RESET;
            st_ff.count       <= `IWD_RESTART_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign rdata_out     = st_ff.rdata;
    assign sys_reset_out = st_ff.sys_reset;
    assign running_out   = st_ff.running;
    assign count_out     = st_ff.count;
    assign irq_out       = st_ff.irq;

endmodule

/* File: verification/iwd_props.sv */
// concurrent checks on the ports of the independent watchdog
`timescale 1ns/1ps
module iwd_props #(
    parameter logic [3:0] SYNC_CYCLES = 4'h6,
    parameter logic [7:0] RESET_PULSE = 8'h10
) (
    input wire logic        sys_clk_in,
    input wire logic        rstn_in,
    input wire logic        osc_clk_in,
    input wire logic        hw_start_in,
    input wire logic        debug_halt_in,
    input wire logic [4:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        sys_reset_out,
    input wire logic        running_out,
    input wire logic [11:0] count_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------
    // register read side
    // ----------------------------------------
    a_read_idle: assert property (!rd_in |=> rdata_out == 32'h0) else $error("read data not zero");
    a_key_reads: assert property (rd_in && addr_in == 5'h00 |=> rdata_out == 32'h0) else $error("key read");
    a_status_bits: assert property (rd_in && addr_in == 5'h0c |=> rdata_out[31:2] == 30'h0) else $error("status");
    a_presc_bits: assert property (rd_in && addr_in == 5'h04 |=> rdata_out[31:3] == 29'h0) else $error("prescaler");
    // ----------------------------------------
    // counter and expiry
    // ----------------------------------------
    a_start_runs: assert property (wr_in && addr_in == 5'h00 && wdata_in[15:0] == 16'hcccc
        |-> ##[1:2] running_out) else $error("start ignored");
    a_pulse_len: assert property ($rose(sys_reset_out) |-> sys_reset_out [*8]) else $error("reset pulse short");
    a_expire_zero: assert property ($rose(sys_reset_out) |-> $past(count_out) == 12'h000
        || $past(count_out, 2) == 12'h000) else $error("expiry not at zero");
    a_count_step: assert property ($past(running_out) && !$past(wr_in) && $past(count_out) != 12'h000
        |-> count_out == $past(count_out) || count_out == $past(count_out) - 12'h1)
        else $error("count jump");
    a_stopped_hold: assert property (!running_out && !wr_in |=> $stable(count_out)) else $error("idle count moved");
    // main scenarios
    c_expiry: cover property ($rose(sys_reset_out));
    c_irq: cover property ($rose(irq_out));
    c_pending: cover property (rd_in && addr_in == 5'h0c ##1 rdata_out[1]);
endmodule

/* File: verification/testbench.sv */
// self-checking testbench of the independent watchdog
`timescale 1ns/1ps
module testbench;
    import iwd_pkg::*;
    logic        sys_clk_in = 1'b0;    // system clock
    logic        rstn_in    = 1'b0;    // reset, active low
    logic        osc_clk_in = 1'b0;    // slow oscillator, period of 8 cycles
    logic [4:0]  addr_in    = 5'h00;
    logic [31:0] wdata_in   = 32'h0;
    logic        wr_in      = 1'b0;
    logic        rd_in      = 1'b0;
    logic        hw_start_in   = 1'b0;    // hardware start option
    logic        debug_halt_in = 1'b0;    // debug freeze
    logic [31:0] rdata_out;
    logic        sys_reset_out;
    logic        running_out;
    logic [11:0] count_out;
    logic        irq_out;
    int          miscompares = 0;
    int          checks_done = 0;
    int          n;
    always #2 sys_clk_in = ~sys_clk_in;
    // oscillator derived from the clock so tick spacing is exact
    initial forever begin
        repeat (4) @(posedge sys_clk_in);
        osc_clk_in <= ~osc_clk_in;
    end
    iwd_top i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .osc_clk_in(osc_clk_in), .hw_start_in(hw_start_in),
        .debug_halt_in(debug_halt_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .sys_reset_out(sys_reset_out), .running_out(running_out),
        .count_out(count_out), .irq_out(irq_out));
    task end_sim;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e, input string nm);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 chk(nm, e, rdata_out);
    endtask
    // waits for the counter to move, counting cycles
    task wait_chg;
        logic [11:0] old;
        old = count_out;
        for (n = 0; n < 5000 && count_out === old; n++) begin
            @(posedge sys_clk_in);
            #1;
        end
        if (n >= 5000) begin
            miscompares++;
            end_sim();
        end
    endtask
    task t_regs;
        rd(5'h04, 32'h0, "presc reset");
        rd(5'h08, 32'hfff, "restart reset");
        rd(5'h0c, 32'h0, "status reset");
        rd(5'h00, 32'h0, "key read");
        rd(5'h1c, 32'h0, "unmapped read");
    endtask
    task t_protect;
        wr(5'h08, 32'h123);
        rd(5'h08, 32'hfff, "locked restart");
        wr(5'h00, 32'h5555);
        wr(5'h08, 32'h123);
        rd(5'h0c, 32'h2, "restart pending");
        wr(5'h08, 32'h456);
        repeat (8) @(posedge sys_clk_in);
        rd(5'h0c, 32'h0, "restart done");
        rd(5'h08, 32'h123, "restart copy");
        wr(5'h04, 32'h7);
        rd(5'h0c, 32'h1, "presc pending");
        wr(5'h04, 32'h2);
        repeat (8) @(posedge sys_clk_in);
        rd(5'h04, 32'h7, "presc copy");
        wr(5'h00, 32'h0);
        wr(5'h08, 32'h321);
        repeat (8) @(posedge sys_clk_in);
        rd(5'h08, 32'h123, "relocked restart");
        wr(5'h00, 32'h5555);
        wr(5'h00, 32'haaaa);
        wr(5'h04, 32'h0);
        repeat (8) @(posedge sys_clk_in);
        rd(5'h04, 32'h7, "refresh relock");
    endtask
    // one divider code: reload, then time a full decrement
    task t_ratio(input logic [2:0] code, input int ratio);
        wr(5'h00, 32'h5555);
        wr(5'h04, {29'h0, code});
        repeat (8) @(posedge sys_clk_in);
        wr(5'h00, 32'haaaa);
        #1 chk("reload value", 32'h123, {20'h0, count_out});
        wait_chg();
        wait_chg();
        chk("tick period", ratio * 8, n);
    endtask
    task t_expire;
        wr(5'h14, 32'h2);
        wr(5'h00, 32'h5555);
        wr(5'h08, 32'h10);
        wr(5'h04, 32'h0);
        repeat (8) @(posedge sys_clk_in);
        wr(5'h00, 32'haaaa);
        rd(5'h10, 32'h1, "refresh event");
        chk("masked irq", 32'h0, {31'h0, irq_out});
        for (n = 0; n < 2000 && sys_reset_out !== 1'b1; n++) begin
            @(posedge sys_clk_in);
            #1;
        end
        if (n >= 2000) begin
            miscompares++;
            end_sim();
        end
        for (n = 0; n < 100 && sys_reset_out === 1'b1; n++) begin
            @(posedge sys_clk_in);
            #1;
        end
        chk("reset pulse", 32'd17, n);
        chk("expiry irq", 32'h1, {31'h0, irq_out});
        rd(5'h10, 32'h2, "expiry event");
        repeat (2) @(posedge sys_clk_in);
        chk("irq cleared", 32'h0, {31'h0, irq_out});
    endtask
    // mid-run reset with the hardware start option, then debug freeze
    task t_hwstart;
        logic [11:0] held;
        @(posedge sys_clk_in);
        rstn_in     <= 1'b0;
        hw_start_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(posedge sys_clk_in);
        #1 chk("hw start running", 32'h1, {31'h0, running_out});
        chk("count after reset", 32'hfff, {20'h0, count_out});
        rd(5'h08, 32'hfff, "restart after reset");
        wr(5'h00, 32'hcccc);
        #1 chk("start ignored", 32'h1, {31'h0, running_out});
        @(posedge sys_clk_in);
        debug_halt_in <= 1'b1;
        @(posedge sys_clk_in);
        #1 held = count_out;
        repeat (100) @(posedge sys_clk_in);
        #1 chk("debug freeze", {20'h0, held}, {20'h0, count_out});
        @(posedge sys_clk_in);
        debug_halt_in <= 1'b0;
        wait_chg();
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_regs();
        t_protect();
        wr(5'h00, 32'hcccc);
        #1 chk("running", 32'h1, {31'h0, running_out});
        t_ratio(3'h0, 4);
        t_ratio(3'h1, 8);
        t_ratio(3'h2, 16);
        t_ratio(3'h5, 128);
        t_ratio(3'h6, 256);
        t_ratio(3'h7, 256);
        t_expire();
        t_hwstart();
        end_sim();
    end
endmodule
bind iwd_top iwd_props #(.SYNC_CYCLES(SYNC_CYCLES), .RESET_PULSE(RESET_PULSE)) i_props (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .osc_clk_in(osc_clk_in), .hw_start_in(hw_start_in),
    .debug_halt_in(debug_halt_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sys_reset_out(sys_reset_out), .running_out(running_out),
    .count_out(count_out), .irq_out(irq_out));
